// ===== logic/cmd_pkg.sv
package cmd_pkg;
	// Command identifiers handled by the decoder
	localparam logic [7:0] CMD_FIX_MODE_REQ = 8'h24;
	localparam logic [7:0] CMD_SOFT_RESET   = 8'h25;
	localparam logic [7:0] CMD_HEALTH_REQ   = 8'h26;
	localparam logic [7:0] CMD_SIG_REQ      = 8'h27;
	localparam logic [7:0] CMD_MSG_REQ      = 8'h28;
	localparam logic [7:0] CMD_ALM_HLTH_REQ = 8'h29;
	localparam logic [7:0] CMD_ALT_2D       = 8'h2A;
	localparam logic [7:0] CMD_INIT_LLA     = 8'h2B;
	localparam logic [7:0] CMD_OSC_REQ      = 8'h2D;
	localparam logic [7:0] CMD_TIME_AID     = 8'h2E;
	localparam logic [7:0] CMD_LEAP_REQ     = 8'h2F;
	localparam logic [7:0] CMD_EXACT_XYZ    = 8'h31;
	localparam logic [7:0] CMD_EXACT_LLA    = 8'h32;
	localparam logic [7:0] CMD_ONE_SV       = 8'h34;

	// Report identifiers
	localparam logic [7:0] RPT_VERSION   = 8'h45;
	localparam logic [7:0] RPT_HEALTH    = 8'h46;
	localparam logic [7:0] RPT_SIG       = 8'h47;
	localparam logic [7:0] RPT_MSG       = 8'h48;
	localparam logic [7:0] RPT_ALM_HLTH  = 8'h49;
	localparam logic [7:0] RPT_ALT       = 8'h4A;
	localparam logic [7:0] RPT_STATUS    = 8'h4B;
	localparam logic [7:0] RPT_OSC       = 8'h4D;
	localparam logic [7:0] RPT_TIME      = 8'h4E;
	localparam logic [7:0] RPT_LEAP      = 8'h4F;
	localparam logic [7:0] RPT_FIX_MODE  = 8'h6D;
	localparam logic [7:0] RPT_SUPER     = 8'h8F;
	localparam logic [7:0] RPT_SUB_NONE  = 8'h00;
	localparam logic [7:0] RPT_SUB_TIMING = 8'hAC;

	// Payload lengths in bytes
	localparam logic [3:0] LEN_NONE   = 4'h0;
	localparam logic [3:0] LEN_BYTE   = 4'h1;
	localparam logic [3:0] LEN_SINGLE = 4'h4;
	localparam logic [3:0] LEN_TIME   = 4'h6;
	localparam logic [3:0] LEN_POS    = 4'hC;
	localparam logic [3:0] LEN_OVER   = 4'hD;

	// Field values and limits
	localparam logic [7:0]  ALT_CANCEL    = 8'hFF;
	localparam logic [7:0]  SV_MAX_PRN    = 8'h20;
	localparam logic [31:0] ALT_LIMIT_BITS = 32'h468CA000;
	localparam logic [31:0] ALT_RESET_VAL = 32'h00000000;
	localparam logic [5:0]  SV_AUTO       = 6'h00;

	// Buffer shape
	localparam int FIFO_WIDTH = 10;
	localparam int FIFO_DEPTH = 4;

	// Decoder states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_BODY = 4'b0010,
		ST_EXEC = 4'b0100,
		ST_RPT  = 4'b1000
	} dec_state_e;
endpackage

// ===== logic/cmd_decoder.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Byte buffer between the framer and the decoder
module cmd_fifo
	import cmd_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          full;
		logic          empty;
	} fifo_s;

	fifo_s            st_reg;
	fifo_s            st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign push      = in_valid & ~st_reg.full;
	assign pop       = out_ready & ~st_reg.empty;
	assign in_ready  = ~st_reg.full;
	assign out_valid = ~st_reg.empty;
	assign out_data  = mem[st_reg.rp];

	// Pointer wrap assumes a power-of-two depth
	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.wp = st_reg.wp + 1'b1;
		end
		if (pop) begin
			st_next.rp = st_reg.rp + 1'b1;
		end
		if (push & ~pop) begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end else if (pop & ~push) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
		st_next.full  = (st_next.cnt == (AW+1)'(DEPTH));
		st_next.empty = (st_next.cnt == '0);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem[st_reg.wp] <= in_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Command decoder and report scheduler
module cmd_decoder
	import cmd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [7:0]  in_data,
	input  wire logic        in_first,
	input  wire logic        in_last,
	output logic             rpt_valid,
	input  wire logic        rpt_ready,
	output logic      [7:0]  rpt_id,
	output logic      [7:0]  rpt_sub,
	input  wire logic        nav_fixing,
	input  wire logic        time_known,
	input  wire logic        alt_geoid_opt,
	input  wire logic        sv_acquired,
	input  wire logic        pos_inaccurate,
	output logic             soft_reset,
	output logic             alt_set,
	output logic             alt_hold,
	output logic             alt_geoid,
	output logic      [31:0] alt_value,
	output logic             nvm_alt_wr,
	output logic             pos_wr,
	output logic             pos_exact,
	output logic             pos_lla,
	output logic      [31:0] pos_a,
	output logic      [31:0] pos_b,
	output logic      [31:0] pos_c,
	output logic             time_wr,
	output logic      [31:0] time_tow,
	output logic      [15:0] time_week,
	output logic             survey_full,
	output logic             traim_flag,
	output logic      [5:0]  one_sv_prn
);
	typedef struct packed {
		dec_state_e  st;
		logic [7:0]  id;
		logic [3:0]  cnt;
		logic [95:0] pay;
		logic        boot;
		logic        rv;
		logic [7:0]  rid;
		logic [7:0]  rsub;
		logic        r2;
		logic [7:0]  r2id;
		logic        srst;
		logic        aset;
		logic        ahold;
		logic        ageo;
		logic [31:0] aval;
		logic        nvw;
		logic        pw;
		logic        pex;
		logic        plla;
		logic [95:0] pos;
		logic        tw;
		logic [31:0] tow;
		logic [15:0] week;
		logic        sfull;
		logic        traim;
		logic [5:0]  prn;
	} dec_s;

	dec_s       s_reg;
	dec_s       s_next;
	logic       f_valid;
	logic       f_ready;
	logic [9:0] f_data;
	logic [7:0] f_byte;
	logic       f_first;
	logic       f_last;
	logic       alt_over;

	// Incoming bytes are buffered so the decoder can stall on reports
	cmd_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.nrst     (nrst),
		.in_valid (in_valid),
		.in_ready (in_ready),
		.in_data  ({in_first, in_last, in_data}),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data (f_data)
	);

	assign f_first = f_data[9];
	assign f_last  = f_data[8];
	assign f_byte  = f_data[7:0];
	// Bytes are drained only while collecting a packet
	assign f_ready = (s_reg.st == ST_IDLE & ~s_reg.boot) | (s_reg.st == ST_BODY);
	// Positive single above limit compares as unsigned bits
	assign alt_over = ~s_reg.aval[31] & (s_reg.aval[30:0] > ALT_LIMIT_BITS[30:0]);

	// Next-state logic: collect, dispatch, report
	always_comb begin
		s_next       = s_reg;
		s_next.srst  = 1'b0;
		s_next.nvw   = 1'b0;
		s_next.pw    = 1'b0;
		s_next.tw    = 1'b0;
		s_next.sfull = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
				if (s_reg.boot) begin
					s_next.boot = 1'b0;
					s_next.rv   = 1'b1;
					s_next.rid  = RPT_VERSION;
					s_next.rsub = RPT_SUB_NONE;
					s_next.st   = ST_RPT;
				end else if (f_valid & f_first) begin
					s_next.id  = f_byte;
					s_next.cnt = LEN_NONE;
					s_next.pay = '0;
					s_next.st  = f_last ? ST_EXEC : ST_BODY;
				end
			end
			ST_BODY: begin
				if (f_valid) begin
					// Saturating count marks oversized packets
					s_next.pay = {s_reg.pay[87:0], f_byte};
					if (s_reg.cnt != LEN_OVER) begin
						s_next.cnt = s_reg.cnt + 1'b1;
					end
					if (f_first) begin
						s_next.id  = f_byte;
						s_next.cnt = LEN_NONE;
						s_next.pay = '0;
					end
					if (f_last) begin
						s_next.st = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				s_next.st   = ST_IDLE;
				s_next.rsub = RPT_SUB_NONE;
				if (s_reg.cnt == LEN_NONE) begin
					s_next.rv = 1'b1;
					case (s_reg.id)
						CMD_FIX_MODE_REQ: s_next.rid = RPT_FIX_MODE;
						CMD_SIG_REQ:      s_next.rid = RPT_SIG;
						CMD_MSG_REQ:      s_next.rid = RPT_MSG;
						CMD_ALM_HLTH_REQ: s_next.rid = RPT_ALM_HLTH;
						CMD_OSC_REQ:      s_next.rid = RPT_OSC;
						CMD_LEAP_REQ:     s_next.rid = RPT_LEAP;
						CMD_HEALTH_REQ: begin
							s_next.rid  = RPT_HEALTH;
							s_next.r2   = 1'b1;
							s_next.r2id = RPT_STATUS;
						end
						CMD_SOFT_RESET: begin
							// Stored settings are untouched here
							s_next.rv   = 1'b0;
							s_next.srst = 1'b1;
							s_next.boot = 1'b1;
						end
						default: s_next.rv = 1'b0;
					endcase
				end else if (s_reg.id == CMD_ALT_2D & s_reg.cnt == LEN_SINGLE) begin
					s_next.aval = s_reg.pay[31:0];
					s_next.ageo = alt_geoid_opt;
					s_next.aset = 1'b1;
					s_next.nvw  = 1'b1;
					s_next.rv   = 1'b1;
					s_next.rid  = RPT_ALT;
				end else if (s_reg.id == CMD_ALT_2D & s_reg.cnt == LEN_BYTE) begin
					if (s_reg.pay[7:0] == ALT_CANCEL) begin
						s_next.aset = 1'b0;
						s_next.aval = ALT_RESET_VAL;
						s_next.nvw  = 1'b1;
					end
				end else if (s_reg.id == CMD_INIT_LLA & s_reg.cnt == LEN_POS) begin
					if (!nav_fixing) begin
						s_next.pos  = s_reg.pay;
						s_next.pw   = 1'b1;
						s_next.pex  = 1'b0;
						s_next.plla = 1'b1;
						s_next.rv   = 1'b1;
						s_next.rid  = RPT_STATUS;
					end
				end else if ((s_reg.id == CMD_EXACT_XYZ | s_reg.id == CMD_EXACT_LLA)
						& s_reg.cnt == LEN_POS) begin
					s_next.pos   = s_reg.pay;
					s_next.plla  = (s_reg.id == CMD_EXACT_LLA);
					s_next.pw    = 1'b1;
					s_next.pex   = 1'b1;
					s_next.sfull = 1'b1;
					s_next.traim = 1'b0;
					s_next.rv    = 1'b1;
					s_next.rid   = RPT_SUPER;
					s_next.rsub  = RPT_SUB_TIMING;
				end else if (s_reg.id == CMD_TIME_AID & s_reg.cnt == LEN_TIME) begin
					if (!time_known) begin
						s_next.tow  = s_reg.pay[47:16];
						s_next.week = s_reg.pay[15:0];
						s_next.tw   = 1'b1;
						s_next.rv   = 1'b1;
						s_next.rid  = RPT_TIME;
					end
				end else if (s_reg.id == CMD_ONE_SV & s_reg.cnt == LEN_BYTE) begin
					if (s_reg.pay[7:0] <= SV_MAX_PRN) begin
						s_next.prn = s_reg.pay[5:0];
					end
				end
				if (s_next.rv) begin
					s_next.st = ST_RPT;
				end
			end
			ST_RPT: begin
				// Second report of a pair follows the first
				if (rpt_ready) begin
					if (s_reg.r2) begin
						s_next.r2  = 1'b0;
						s_next.rid = s_reg.r2id;
					end else begin
						s_next.rv = 1'b0;
						s_next.st = ST_IDLE;
					end
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
		// Export limit: an acquisition restarts the receiver only while a set altitude is above the limit
		if (sv_acquired & s_reg.aset & alt_over) begin
			s_next.srst = 1'b1;
			s_next.boot = 1'b1;
		end
		// Flag set wins over the clear by a new position
		if (s_reg.pex & pos_inaccurate) begin
			s_next.traim = 1'b1;
		end
		// Hold mode kept as its own flop so the pin has no gate after the register
		s_next.ahold = ~s_next.aset;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_reg      <= '0;
			s_reg.st   <= ST_IDLE;
			s_reg.boot <= 1'b1;
			s_reg.prn  <= SV_AUTO;
			s_reg.ahold <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign rpt_valid   = s_reg.rv;
	assign rpt_id      = s_reg.rid;
	assign rpt_sub     = s_reg.rsub;
	assign soft_reset  = s_reg.srst;
	assign alt_set     = s_reg.aset;
	assign alt_hold    = s_reg.ahold;
	assign alt_geoid   = s_reg.ageo;
	assign alt_value   = s_reg.aval;
	assign nvm_alt_wr  = s_reg.nvw;
	assign pos_wr      = s_reg.pw;
	assign pos_exact   = s_reg.pex;
	assign pos_lla     = s_reg.plla;
	assign pos_a       = s_reg.pos[95:64];
	assign pos_b       = s_reg.pos[63:32];
	assign pos_c       = s_reg.pos[31:0];
	assign time_wr     = s_reg.tw;
	assign time_tow    = s_reg.tow;
	assign time_week   = s_reg.week;
	assign survey_full = s_reg.sfull;
	assign traim_flag  = s_reg.traim;
	assign one_sv_prn  = s_reg.prn;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_fix_mode;
		@(posedge clk) disable iff (!nrst)
		(s_reg.st == ST_EXEC & s_reg.id == CMD_FIX_MODE_REQ & s_reg.cnt == LEN_NONE)
		|=> rpt_valid & rpt_id == RPT_FIX_MODE;
	endproperty
	a_fix_mode: assert property (p_fix_mode) else $error("fix mode report missing");

	property p_soft_reset;
		@(posedge clk) disable iff (!nrst)
		$rose(soft_reset) |-> ##[1:3] (rpt_valid & rpt_id == RPT_VERSION);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("no version after reset");

	property p_version_only_boot;
		@(posedge clk) disable iff (!nrst)
		$rose(rpt_valid) & rpt_id == RPT_VERSION |-> $past(s_reg.boot);
	endproperty
	a_version_only_boot: assert property (p_version_only_boot) else $error("spurious version");

	property p_health_pair;
		@(posedge clk) disable iff (!nrst)
		(rpt_valid & rpt_ready & rpt_id == RPT_HEALTH) |=> rpt_valid & rpt_id == RPT_STATUS;
	endproperty
	a_health_pair: assert property (p_health_pair) else $error("health pair broken");

	property p_alt_cancel;
		@(posedge clk) disable iff (!nrst)
		(s_reg.st == ST_EXEC & s_reg.id == CMD_ALT_2D & s_reg.cnt == LEN_BYTE
			& s_reg.pay[7:0] == ALT_CANCEL) |=> !alt_set & alt_value == ALT_RESET_VAL & nvm_alt_wr;
	endproperty
	a_alt_cancel: assert property (p_alt_cancel) else $error("altitude cancel failed");

	property p_lla_discard;
		@(posedge clk) disable iff (!nrst)
		(s_reg.st == ST_EXEC & s_reg.id == CMD_INIT_LLA & nav_fixing) |=> !pos_wr & !rpt_valid;
	endproperty
	a_lla_discard: assert property (p_lla_discard) else $error("position taken while fixing");

	property p_time_ignore;
		@(posedge clk) disable iff (!nrst)
		(s_reg.st == ST_EXEC & s_reg.id == CMD_TIME_AID & time_known) |=> !time_wr;
	endproperty
	a_time_ignore: assert property (p_time_ignore) else $error("time aiding not ignored");

	property p_exact_survey;
		@(posedge clk) disable iff (!nrst)
		survey_full |-> pos_wr & pos_exact & rpt_valid & rpt_sub == RPT_SUB_TIMING;
	endproperty
	a_exact_survey: assert property (p_exact_survey) else $error("exact position effects missing");

	property p_traim;
		@(posedge clk) disable iff (!nrst)
		(pos_exact & pos_inaccurate) |=> traim_flag;
	endproperty
	a_traim: assert property (p_traim) else $error("integrity flag not raised");

	property p_prn_range;
		@(posedge clk) disable iff (!nrst)
		one_sv_prn <= SV_MAX_PRN[5:0];
	endproperty
	a_prn_range: assert property (p_prn_range) else $error("satellite number out of range");

	property p_limit_reset;
		@(posedge clk) disable iff (!nrst)
		(sv_acquired & alt_set & alt_over) |=> soft_reset;
	endproperty
	a_limit_reset: assert property (p_limit_reset) else $error("limit reset missing");
endmodule

// ===== testbench/host_link.sv
`timescale 1ns/1ps

////////////////////////////////////////
// Host side of the command byte link
module host_link (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       slow,
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic      [7:0] in_data,
	output logic            in_first,
	output logic            in_last
);
	logic [9:0] q[$];
	logic [9:0] cur;

	// Packets are queued whole: id byte first, last byte marked
	function void push(input logic [9:0] b);
		q.push_back(b);
	endfunction

	function automatic int pending();
		return q.size() + ((in_valid === 1'b1) ? 1 : 0);
	endfunction

	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		in_first = 1'b0;
		in_last = 1'b0;
	end

	// Hold each byte until taken; idle data toggles so stale bytes never look valid
	always @(posedge clk) begin
		if (!nrst) begin
			in_valid <= 1'b0;
		end else if (!in_valid || in_ready) begin
			if (q.size() > 0 && !(slow && in_valid)) begin
				cur = q.pop_front();
				in_valid <= 1'b1;
				{in_first, in_last, in_data} <= cur;
			end else begin
				in_valid <= 1'b0;
				in_data <= ~in_data;
			end
		end
	end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps

module tb
	import cmd_pkg::*;
;
	logic        clk, nrst, slow, stall, in_valid, in_ready, in_first, in_last, rpt_valid, rpt_ready;
	logic [7:0]  in_data, rpt_id, rpt_sub;
	logic        nav_fixing, time_known, alt_geoid_opt, sv_acquired, pos_inaccurate;
	logic        soft_reset, alt_set, alt_hold, alt_geoid, nvm_alt_wr, pos_wr, pos_exact, pos_lla;
	logic        time_wr, survey_full, traim_flag;
	logic [31:0] alt_value, pos_a, pos_b, pos_c, time_tow, alt_m, pa_m, pb_m, pc_m, tow_m, v, w;
	logic [15:0] time_week, week_m;
	logic [5:0]  one_sv_prn, prn_m;
	logic [95:0] p;
	logic [31:0] seed, rdy_seed;
	logic        alt_set_m, geoid_m, exact_m, lla_m, traim_m;
	logic [15:0] exp_q[$];
	int          failures, checks, cycles, sr_n, sf_n, pw_n, tw_n, nvm_n, sr_m, sf_m, pw_m, tw_m, nvm_m;
	logic [7:0]  req_id[7] = '{CMD_FIX_MODE_REQ, CMD_HEALTH_REQ, CMD_SIG_REQ, CMD_MSG_REQ, CMD_ALM_HLTH_REQ,
		CMD_OSC_REQ, CMD_LEAP_REQ};
	logic [7:0]  rsp_id[7] = '{RPT_FIX_MODE, RPT_HEALTH, RPT_SIG, RPT_MSG, RPT_ALM_HLTH, RPT_OSC, RPT_LEAP};
	logic [7:0]  sv_v[5] = '{8'h05, 8'h20, 8'h21, 8'h00, 8'h01};

	cmd_decoder cmd_decoder_inst (
		.clk(clk), .nrst(nrst), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.in_first(in_first), .in_last(in_last), .rpt_valid(rpt_valid), .rpt_ready(rpt_ready),
		.rpt_id(rpt_id), .rpt_sub(rpt_sub), .nav_fixing(nav_fixing), .time_known(time_known),
		.alt_geoid_opt(alt_geoid_opt), .sv_acquired(sv_acquired), .pos_inaccurate(pos_inaccurate),
		.soft_reset(soft_reset), .alt_set(alt_set), .alt_hold(alt_hold), .alt_geoid(alt_geoid),
		.alt_value(alt_value), .nvm_alt_wr(nvm_alt_wr), .pos_wr(pos_wr), .pos_exact(pos_exact),
		.pos_lla(pos_lla), .pos_a(pos_a), .pos_b(pos_b), .pos_c(pos_c), .time_wr(time_wr),
		.time_tow(time_tow), .time_week(time_week), .survey_full(survey_full),
		.traim_flag(traim_flag), .one_sv_prn(one_sv_prn));

	host_link host_link_inst (
		.clk(clk), .nrst(nrst), .slow(slow), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .in_first(in_first), .in_last(in_last));

	////////////////////////////////////////
	// Shared helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function logic [31:0] rnd();
		seed = lfsr(seed);
		return seed;
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Payload goes out big-endian, low n bytes of pv
	task automatic pkt(input logic [7:0] id, input int n, input logic [95:0] pv);
		host_link_inst.push({1'b1, n == 0, id});
		for (int i = 0; i < n; i++) begin
			host_link_inst.push({1'b0, i == n - 1, pv[(n - 1 - i) * 8 +: 8]});
		end
	endtask

	// Bounded wait for the link and the report queue to drain
	task automatic run();
		int k;
		k = 0;
		while ((host_link_inst.pending() != 0 || exp_q.size() != 0) && k < 2000) begin
			@(posedge clk);
			k++;
		end
		repeat (12) @(posedge clk);
		if (exp_q.size() != 0)
			chk("reports missing", 0, exp_q.size());
		exp_q.delete();
	endtask

	task automatic state();
		chk("alt_value", alt_m, alt_value);
		chk("alt_set", alt_set_m, alt_set);
		chk("alt_hold", !alt_set_m, alt_hold);
		if (alt_set_m) chk("alt_geoid", geoid_m, alt_geoid);
		chk("nvm_alt_wr", nvm_m, nvm_n);
		chk("pos_a", pa_m, pos_a);
		chk("pos_b", pb_m, pos_b);
		chk("pos_c", pc_m, pos_c);
		chk("pos_lla", lla_m, pos_lla);
		chk("pos_exact", exact_m, pos_exact);
		chk("pos_wr", pw_m, pw_n);
		chk("time_tow", tow_m, time_tow);
		chk("time_week", week_m, time_week);
		chk("time_wr", tw_m, tw_n);
		chk("survey_full", sf_m, sf_n);
		chk("traim_flag", traim_m, traim_flag);
		chk("one_sv_prn", prn_m, one_sv_prn);
		chk("soft_reset", sr_m, sr_n);
	endtask

	////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Consumer stalls at random so incoming command bytes back up into the buffer
	always @(posedge clk) begin
		rdy_seed = lfsr(rdy_seed);
		rpt_ready <= !stall && rdy_seed[4:3] != 2'b00;
	end

	// Every report taken is compared with the next expected one
	always @(posedge clk) begin
		if (nrst && rpt_valid === 1'b1 && rpt_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("unrequested report", 32'hFFFF, {rpt_id, rpt_sub});
			else
				chk("report", exp_q.pop_front(), {rpt_id, rpt_sub});
		end
	end

	// Pulse counters and run limit
	always @(posedge clk) begin
		if (nrst && soft_reset === 1'b1) sr_n++;
		if (nrst && survey_full === 1'b1) sf_n++;
		if (nrst && pos_wr === 1'b1) pw_n++;
		if (nrst && time_wr === 1'b1) tw_n++;
		if (nrst && nvm_alt_wr === 1'b1) nvm_n++;
		cycles++;
		if (cycles >= 20000) begin
			failures++;
			end_sim();
		end
	end

	////////////////////////////////////////
	// Main sequence
	initial begin
		{nrst, slow, stall, rpt_ready, nav_fixing, time_known, alt_geoid_opt, sv_acquired, pos_inaccurate} = '0;
		{alt_m, pa_m, pb_m, pc_m, tow_m, week_m, prn_m, alt_set_m, geoid_m, exact_m, lla_m, traim_m} = '0;
		seed = 32'hC1A8;
		rdy_seed = 32'hC1A8;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		exp_q.push_back({RPT_VERSION, RPT_SUB_NONE});
		run();
		// Requests back to back while the consumer is stalled: the buffer must refuse
		stall <= 1'b1;
		foreach (req_id[i]) begin
			pkt(req_id[i], 0, 0);
			exp_q.push_back({rsp_id[i], RPT_SUB_NONE});
			if (req_id[i] == CMD_HEALTH_REQ) exp_q.push_back({RPT_STATUS, RPT_SUB_NONE});
		end
		repeat (40) @(posedge clk);
		chk("in_ready while full", 0, in_ready);
		stall <= 1'b0;
		run();
		slow <= 1'b1;
		// Altitude set, a wrong length, a one-byte value other than cancel, cancel
		alt_geoid_opt <= 1'b1;
		alt_m = rnd();
		pkt(CMD_ALT_2D, 4, alt_m);
		exp_q.push_back({RPT_ALT, RPT_SUB_NONE});
		{alt_set_m, geoid_m} = 2'b11;
		nvm_m++;
		run();
		state();
		pkt(CMD_ALT_2D, 2, 16'hFFFF);
		pkt(CMD_ALT_2D, 1, 8'h7E);
		// Cut altitude packet: a new id byte inside the body restarts decoding
		host_link_inst.push({1'b1, 1'b0, CMD_ALT_2D});
		host_link_inst.push({1'b0, 1'b0, 8'h11});
		pkt(CMD_FIX_MODE_REQ, 0, 0);
		exp_q.push_back({RPT_FIX_MODE, RPT_SUB_NONE});
		run();
		state();
		pkt(CMD_ALT_2D, 1, ALT_CANCEL);
		{alt_m, alt_set_m} = '0;
		nvm_m++;
		run();
		state();
		// Initial position: discarded while fixing, then taken
		nav_fixing <= 1'b1;
		pkt(CMD_INIT_LLA, 12, {rnd(), rnd(), rnd()});
		run();
		state();
		nav_fixing <= 1'b0;
		p = {rnd(), rnd(), rnd()};
		pkt(CMD_INIT_LLA, 12, p);
		exp_q.push_back({RPT_STATUS, RPT_SUB_NONE});
		{pa_m, pb_m, pc_m, lla_m, exact_m} = {p, 2'b10};
		pw_m++;
		run();
		state();
		// Time aiding: ignored once time is known, then taken
		v = rnd();
		w = rnd();
		time_known <= 1'b1;
		pkt(CMD_TIME_AID, 6, {v, w[15:0]});
		run();
		state();
		time_known <= 1'b0;
		pkt(CMD_TIME_AID, 6, {v, w[15:0]});
		exp_q.push_back({RPT_TIME, RPT_SUB_NONE});
		{tow_m, week_m} = {v, w[15:0]};
		tw_m++;
		run();
		state();
		// Exact positions: XYZ inaccurate, LLA still inaccurate (set beats clear), XYZ accurate clears
		nav_fixing <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			pos_inaccurate <= (i != 2);
			p = {rnd(), rnd(), rnd()};
			pkt(i == 1 ? CMD_EXACT_LLA : CMD_EXACT_XYZ, 12, p);
			exp_q.push_back({RPT_SUPER, RPT_SUB_TIMING});
			{pa_m, pb_m, pc_m, lla_m, exact_m, traim_m} = {p, i == 1, 1'b1, i != 2};
			pw_m++;
			sf_m++;
			run();
			repeat (2) @(posedge clk);
			state();
		end
		nav_fixing <= 1'b0;
		pos_inaccurate <= 1'b0;
		// One-satellite selection, including an out-of-range number
		foreach (sv_v[i]) begin
			pkt(CMD_ONE_SV, 1, sv_v[i]);
			if (sv_v[i] <= SV_MAX_PRN) prn_m = sv_v[i][5:0];
			run();
			state();
		end
		// Seventeen data bytes: a wrapping length count would see one byte and accept it
		host_link_inst.push({1'b1, 1'b0, CMD_ONE_SV});
		for (int i = 0; i < 17; i++)
			host_link_inst.push({1'b0, i == 16, 8'h07});
		run();
		state();
		// Soft reset keeps settings and re-announces the version
		pkt(CMD_SOFT_RESET, 0, 0);
		sr_m++;
		exp_q.push_back({RPT_VERSION, RPT_SUB_NONE});
		run();
		state();
		// Altitude at and just above the export limit, then a satellite acquisition
		alt_geoid_opt <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			alt_m = ALT_LIMIT_BITS + i;
			pkt(CMD_ALT_2D, 4, alt_m);
			exp_q.push_back({RPT_ALT, RPT_SUB_NONE});
			{alt_set_m, geoid_m} = 2'b10;
			nvm_m++;
			run();
			sv_acquired <= 1'b1;
			@(posedge clk);
			sv_acquired <= 1'b0;
			if (i == 1) begin
				sr_m++;
				exp_q.push_back({RPT_VERSION, RPT_SUB_NONE});
			end
			run();
			state();
		end
		end_sim();
	end
endmodule
